// File: dv/receiver_control_register_bank_properties.sv
// Checker of the register bank outputs over time.
// Assumes calibration lengths are handed on by the bind.
`timescale 1ns/1ps
module receiver_control_register_bank_properties #(
   parameter int unsigned POL_CAL_CYCLES = 1000,
   parameter int unsigned FSK_CAL_SHORT_CYCLES = 500,
   parameter int unsigned FSK_CAL_LONG_CYCLES = 4000
) (
   input logic clock,
   input logic arst_n,
   input logic chipSelect_n,
   input logic dioOut,
   input logic dioOe_n,
   input rx_ctrl_pkg::power_s modulePower,
   input logic peakDetectorsEnable,
   input logic dataOutputsEnable,
   input rx_ctrl_pkg::options_s deviceOptions,
   input logic [7:0] crystalDivisor,
   input logic pollingCalibrationBusy,
   input logic freqShiftCalibrationBusy
);
   import rx_ctrl_pkg::*;
   logic duty_cycled_receive, outsOff;
   int fskLen;
   logic [15:0] polCnt_ff, fskCnt_ff;
   assign duty_cycled_receive = deviceOptions.dutyCycledReceiveSelect;
   assign outsOff = !peakDetectorsEnable && !dataOutputsEnable;
   assign fskLen = deviceOptions.longCalibrationSelect ?
      FSK_CAL_LONG_CYCLES : FSK_CAL_SHORT_CYCLES;
   // Length of the current busy run of each calibration
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         polCnt_ff <= '0;
         fskCnt_ff <= '0;
      end else begin
         polCnt_ff <= pollingCalibrationBusy ? polCnt_ff + 16'h1 : '0;
         fskCnt_ff <= freqShiftCalibrationBusy ? fskCnt_ff + 16'h1 : '0;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_wake_drive_low: assert property (
      duty_cycled_receive && chipSelect_n && !dioOe_n |-> !dioOut) else $error("wake high");
   a_settle_outs_off: assert property (
      duty_cycled_receive && chipSelect_n && !dioOe_n |-> outsOff) else $error("outs on");
   a_sleep_all_off: assert property (
      duty_cycled_receive && modulePower.deepSleep |-> outsOff && modulePower[7:1] == 7'h00)
      else $error("module on in sleep");
   a_pol_cal_len: assert property (
      $fell(pollingCalibrationBusy) |->
      polCnt_ff inside {[POL_CAL_CYCLES-1:POL_CAL_CYCLES+1]})
      else $error("polling cal length");
   a_fsk_cal_len: assert property (
      $fell(freqShiftCalibrationBusy) |->
      fskCnt_ff inside {[fskLen-1:fskLen+1]})
      else $error("fsk cal length");
   a_cal_on_write: assert property (
      $rose(freqShiftCalibrationBusy) |-> chipSelect_n)
      else $error("cal start in frame");
   a_dio_release: assert property (
      $rose(chipSelect_n) && !duty_cycled_receive |-> ##[0:6] dioOe_n)
      else $error("line not released");
   a_reg_update: assert property (
      !$stable(crystalDivisor) |-> chipSelect_n) else $error("early update");
   c_fsk_done: cover property ($fell(freqShiftCalibrationBusy));
   c_wake_low: cover property (duty_cycled_receive && chipSelect_n && !dioOe_n);
   c_active: cover property (duty_cycled_receive && peakDetectorsEnable);
endmodule
bind receiver_control_register_bank receiver_control_register_bank_properties
   #(.POL_CAL_CYCLES(POL_CAL_CYCLES),
   .FSK_CAL_SHORT_CYCLES(FSK_CAL_SHORT_CYCLES),
   .FSK_CAL_LONG_CYCLES(FSK_CAL_LONG_CYCLES)) checker_i (.clock(clock),
   .arst_n(arst_n), .chipSelect_n(chipSelect_n), .dioOut(dioOut),
   .dioOe_n(dioOe_n), .modulePower(modulePower),
   .peakDetectorsEnable(peakDetectorsEnable),
   .dataOutputsEnable(dataOutputsEnable), .deviceOptions(deviceOptions),
   .crystalDivisor(crystalDivisor),
   .pollingCalibrationBusy(pollingCalibrationBusy),
   .freqShiftCalibrationBusy(freqShiftCalibrationBusy));

// File: dv/receiver_control_register_bank_tb.sv
// Self-checking bench of the receiver register bank.
// Assumes the host model runs frames on a 64 ns serial clock.
`timescale 1ns/1ps
module receiver_control_register_bank_tb;
   import rx_ctrl_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic cs_n, sck, hDrv, hOe_n, shared_serial_data_line, dOut, dOe_n, fOut, aOut;
   logic pk, de, gl, ft, at, polBusy, fskBusy, sawSleep, sawCal;
   analog_status_s analogStatus = '0;
   power_s pwr;
   options_s opt;
   logic [7:0] div, q;
   logic [4:0] dwell;
   logic [7:0] shadow [16];
   int numErrors = 0;
   int checkCount = 0;
   int cycles = 0;
   int seed = 32'h6946babb;
   localparam int OFF_UNIT = 20;
   always #4 clock = ~clock;
   receiver_control_register_bank #(.WAKE_UNIT_CYCLES(10),
      .OFF_BASE0_CYCLES(OFF_UNIT))
   receiver_control_register_bank_i (.clock(clock), .arst_n(arst_n),
      .chipSelect_n(cs_n), .serialClock(sck), .dioIn(shared_serial_data_line), .dioOut(dOut),
      .dioOe_n(dOe_n), .freqSerialOut(fOut), .ampSerialOut(aOut),
      .analogStatus(analogStatus), .modulePower(pwr),
      .peakDetectorsEnable(pk), .dataOutputsEnable(de),
      .deviceOptions(opt), .gainLock(gl), .freqPeakTrackingEnable(ft),
      .ampPeakTrackingEnable(at), .crystalDivisor(div),
      .gainReleaseDwell(dwell), .pollingCalibrationBusy(polBusy),
      .freqShiftCalibrationBusy(fskBusy));
   rx_host_model rx_host_model_i (.clock(clock), .dioIn(shared_serial_data_line),
      .chipSelect_n(cs_n), .serialClock(sck), .hostDrv(hDrv),
      .hostOe_n(hOe_n));
   assign shared_serial_data_line = !dOe_n ? dOut : (!hOe_n ? hDrv : 1'b1);
   task automatic check(input string nm, input logic [15:0] s, e);
      checkCount++;
      if (s !== e) begin
         numErrors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic giveVerdict();
      $display("checks %0d errors %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         numErrors++;
         giveVerdict();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      rx_host_model_i.frame({CMD_WRITE, a, d}, 1'b0, q);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      rx_host_model_i.frame({CMD_READ, a, 8'h00}, 1'b0, d);
      rx_host_model_i.frame(16'h0000, 1'b1, d);
   endtask
   function automatic logic [7:0] keep(input logic [3:0] a, input logic w);
      if (a == ADDR_OPTIONS)
         return w ? 8'he6 : OPTIONS_MASK;
      if (a == ADDR_CONTROL)
         return w ? 8'hfc : CONTROL_MASK;
      return 8'hff;
   endfunction
   task automatic checkDefaults();
      logic [7:0] v;
      for (int a = 0; a < 12; a++) begin
         rd(4'(a), v);
         check("reset value", v, a == 1 ? RST_OPTIONS :
            (a == 10 ? RST_DWELL : RST_ZERO));
      end
      $display("test defaults done");
   endtask
   task automatic waitOe(input logic val, output int n);
      n = 0;
      while (dOe_n !== val && n < 400) begin
         @(posedge clock);
         n++;
         sawSleep |= pwr.deepSleep;
         sawCal |= polBusy;
      end
   endtask
   initial begin
      logic [7:0] v, w;
      logic [3:0] a;
      int n;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      checkDefaults();
      for (int k = 0; k < 20; k++) begin
         a = k % 10 == 9 ? ADDR_DWELL : 4'(k % 10);
         w = 8'($random(seed)) & keep(a, 1'b1);
         wr(a, w);
         rd(a, v);
         shadow[a] = w & keep(a, 1'b0);
         check("readback", v, shadow[a]);
      end
      check("divisor", div, shadow[3]);
      check("outputs", {dwell, opt},
         {shadow[10][4:0], shadow[1]});
      check("control", {gl, ft, at}, {shadow[2][6], shadow[2][3:2]});
      rx_host_model_i.frame({4'h5, ADDR_DIVISOR, 8'ha5}, 1'b0, q);
      rx_host_model_i.frame({CMD_NOP, ADDR_DIVISOR, 8'h5a}, 1'b0, q);
      wr(ADDR_STATUS, 8'hff);
      rd(ADDR_STATUS, v);
      check("ignored", {v, div}, {8'h00, shadow[3]});
      $display("test registers done");
      wr(ADDR_DIVISOR, 8'h5f);
      wr(ADDR_POWER, 8'hfe);
      for (int l = 0; l < 2; l++) begin
         analogStatus <= 3'($random(seed));
         wr(ADDR_OPTIONS, l ? 8'h60 : 8'h40);
         wr(ADDR_CONTROL, l ? 8'h03 : 8'h01);
         n = 0;
         for (int t = 0; t < 5000 && (polBusy || fskBusy); t++) begin
            @(posedge clock);
            n += fskBusy;
         end
         check("cal length", n > 2000, l[0]);
         rd(ADDR_CONTROL, v);
         check("requests", v, 8'h00);
         rd(ADDR_STATUS, v);
         check("status", v, {analogStatus, 3'h0, l[0], 1'b1});
      end
      $display("test calibration done");
      analogStatus <= '0;
      rx_host_model_i.frame({CMD_MASTER_RESET, 12'h000}, 1'b0, q);
      checkDefaults();
      wr(ADDR_POWER, 8'hfe);
      wr(ADDR_SLEEP_LO, 8'h02);
      wr(ADDR_HOST_WAKE, 8'h01);
      wr(ADDR_SETTLE_LO, 8'h05);
      wr(ADDR_OPTIONS, 8'h01);
      sawSleep = 1'b0;
      rx_host_model_i.holdLine(1'b0);
      waitOe(1'b0, n);
      check("off length", n inside {[2*OFF_UNIT:2*OFF_UNIT+10]},
         1'b1);
      check("off power", sawSleep, 1'b1);
      sawCal = 1'b0;
      rx_host_model_i.holdLine(1'b1);
      waitOe(1'b1, n);
      check("wake length", n inside {[59:63]}, 1'b1);
      check("auto cal", sawCal, 1'b1);
      repeat (12) @(posedge clock);
      check("active", {pk, de}, 2'b11);
      rx_host_model_i.holdLine(1'b0);
      waitOe(1'b0, n);
      check("restart", pk, 1'b0);
      waitOe(1'b1, n);
      repeat (12) @(posedge clock);
      check("no answer", {pk, pwr.deepSleep}, 2'b01);
      $display("test duty cycle done");
      giveVerdict();
   end
endmodule

// File: dv/rx_host_model.sv
// Host controller model driving the serial control port.
// Assumes the bench resolves the shared line, with a pull-up.
`timescale 1ns/1ps
module rx_host_model (
   input wire logic clock,
   input wire logic dioIn,
   output logic chipSelect_n,
   output logic serialClock,
   output logic hostDrv,
   output logic hostOe_n
);
   initial begin
      chipSelect_n = 1'b1;
      serialClock = 1'b0;
      hostDrv = 1'b0;
      hostOe_n = 1'b0;
   end
   // Line held low while idle keeps the duty cycle from starting
   task automatic holdLine(input logic en);
      hostOe_n <= !en;
      hostDrv <= 1'b0;
   endtask
   // One 16-bit frame, 64 ns serial clock; rd leaves the line to the device
   task automatic frame(input logic [15:0] w, input logic rd,
         output logic [7:0] q);
      @(posedge clock);
      chipSelect_n <= 1'b0;
      hostOe_n <= rd;
      repeat (6) @(posedge clock);
      for (int i = 15; i >= 0; i--) begin
         hostDrv <= w[i];
         repeat (4) @(posedge clock);
         serialClock <= 1'b1;
         repeat (4) @(posedge clock);
         if (i > 7) q[i-8] = dioIn;
         serialClock <= 1'b0;
      end
      repeat (4) @(posedge clock);
      chipSelect_n <= 1'b1;
      holdLine(1'b1);
      repeat (10) @(posedge clock);
   endtask
endmodule

// File: logic/receiver_control_register_bank.sv
// Register bank, serial control port and duty-cycle sequencer of the
// receiver. Assumes serial pins and analog status arrive asynchronously.
`timescale 1ns/1ps
module receiver_control_register_bank #(
   parameter int unsigned WAKE_UNIT_CYCLES = rx_ctrl_pkg::WAKE_UNIT_CYC,
   parameter int unsigned OFF_BASE0_CYCLES = 125,
   parameter int unsigned OFF_BASE1_CYCLES = 500,
   parameter int unsigned OFF_BASE2_CYCLES = 2000,
   parameter int unsigned OFF_BASE3_CYCLES = 8000,
   parameter int unsigned POL_CAL_CYCLES = 1000,
   parameter int unsigned FSK_CAL_SHORT_CYCLES = 500,
   parameter int unsigned FSK_CAL_LONG_CYCLES = 4000
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic chipSelect_n,
   input wire logic serialClock,
   input wire logic dioIn,
   output logic dioOut,
   output logic dioOe_n,
   output logic freqSerialOut,
   output logic ampSerialOut,
   input wire rx_ctrl_pkg::analog_status_s analogStatus,
   output rx_ctrl_pkg::power_s modulePower,
   output logic peakDetectorsEnable,
   output logic dataOutputsEnable,
   output rx_ctrl_pkg::options_s deviceOptions,
   output logic gainLock,
   output logic freqPeakTrackingEnable,
   output logic ampPeakTrackingEnable,
   output logic [7:0] crystalDivisor,
   output logic [4:0] gainReleaseDwell,
   output logic pollingCalibrationBusy,
   output logic freqShiftCalibrationBusy
);
   import rx_ctrl_pkg::*;

   initial begin
      if (WAKE_UNIT_CYCLES < 1 || OFF_BASE0_CYCLES < 1 ||
         POL_CAL_CYCLES < 1 || FSK_CAL_SHORT_CYCLES < 1 ||
         FSK_CAL_LONG_CYCLES < 1 || WAKE_UNIT_CYCLES >= 2**24 ||
         OFF_BASE3_CYCLES >= 2**24 || FSK_CAL_LONG_CYCLES >= 2**24)
         $error("receiver_control_register_bank: bad timing parameter");
   end

   function automatic logic [23:0] to24(input int unsigned v);
      to24 = v[23:0];
   endfunction

   // Input synchronisers
   logic [1:0] csSync_ff, sclkSync_ff, dioSync_ff;
   analog_status_s anaMeta_ff, anaSync_ff;
   logic csPrev_ff, sclkPrev_ff;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         csSync_ff <= 2'h3;
         sclkSync_ff <= 2'h0;
         dioSync_ff <= 2'h0;
         anaMeta_ff <= 3'h0;
         anaSync_ff <= 3'h0;
         csPrev_ff <= 1'b1;
         sclkPrev_ff <= 1'b0;
      end else begin
         csSync_ff <= {csSync_ff[0], chipSelect_n};
         sclkSync_ff <= {sclkSync_ff[0], serialClock};
         dioSync_ff <= {dioSync_ff[0], dioIn};
         anaMeta_ff <= analogStatus;
         anaSync_ff <= anaMeta_ff;
         csPrev_ff <= csSync_ff[1];
         sclkPrev_ff <= sclkSync_ff[1];
      end
   end
   logic csHigh, dioHigh, frameStart, frameEnd, sclkRise, sclkFall;
   assign csHigh = csSync_ff[1];
   assign dioHigh = dioSync_ff[1];
   assign frameStart = csPrev_ff && !csHigh;
   assign frameEnd = !csPrev_ff && csHigh;
   assign sclkRise = !csHigh && sclkSync_ff[1] && !sclkPrev_ff;
   assign sclkFall = !csHigh && !sclkSync_ff[1] && sclkPrev_ff;

   // Serial frame capture
   logic [15:0] shiftIn_ff;
   logic [4:0] bitCnt_ff;
   logic readFrame_ff;
   logic [7:0] readShift_ff;
   logic masterReset_ff;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         shiftIn_ff <= 16'h0000;
         bitCnt_ff <= 5'h00;
      end else if (frameStart) begin
         bitCnt_ff <= 5'h00;
      end else if (sclkRise && bitCnt_ff < 5'(FRAME_BITS)) begin
         shiftIn_ff <= {shiftIn_ff[14:0], dioHigh};
         bitCnt_ff <= bitCnt_ff + 5'h01;
      end
   end
   logic frameDone;
   logic [3:0] frameCmd, frameAddr;
   logic [7:0] frameData;
   assign frameDone = frameEnd && !readFrame_ff &&
      bitCnt_ff == 5'(FRAME_BITS);
   assign frameCmd = shiftIn_ff[15:12];
   assign frameAddr = shiftIn_ff[11:8];
   assign frameData = shiftIn_ff[7:0];
   logic regWrite;
   assign regWrite = frameDone && frameCmd == CMD_WRITE &&
      !masterReset_ff;

   // Master reset holds while chip select stays high
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         masterReset_ff <= 1'b0;
      else if (frameDone && frameCmd == CMD_MASTER_RESET)
         masterReset_ff <= 1'b1;
      else if (!csHigh)
         masterReset_ff <= 1'b0;
   end

   // Registers
   power_s power_ff;
   options_s options_ff;
   logic [7:0] control_ff, divisor_ff, sleepHi_ff, sleepLo_ff;
   logic [7:0] hostWake_ff, settleHi_ff, settleLo_ff, dwell_ff;
   logic polDone_ff, fskDone_ff, polFinish, fskFinish;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         power_ff <= RST_ZERO;
         options_ff <= RST_OPTIONS;
         divisor_ff <= RST_ZERO;
         sleepHi_ff <= RST_ZERO;
         sleepLo_ff <= RST_ZERO;
         hostWake_ff <= RST_ZERO;
         settleHi_ff <= RST_ZERO;
         settleLo_ff <= RST_ZERO;
         dwell_ff <= RST_DWELL;
      end else if (masterReset_ff) begin
         power_ff <= RST_ZERO;
         options_ff <= RST_OPTIONS;
         divisor_ff <= RST_ZERO;
         sleepHi_ff <= RST_ZERO;
         sleepLo_ff <= RST_ZERO;
         hostWake_ff <= RST_ZERO;
         settleHi_ff <= RST_ZERO;
         settleLo_ff <= RST_ZERO;
         dwell_ff <= RST_DWELL;
      end else if (regWrite) begin
         unique case (frameAddr)
            ADDR_POWER: power_ff <= frameData;
            ADDR_OPTIONS: options_ff <= frameData & OPTIONS_MASK;
            ADDR_DIVISOR: divisor_ff <= frameData;
            ADDR_SLEEP_HI: sleepHi_ff <= frameData;
            ADDR_SLEEP_LO: sleepLo_ff <= frameData;
            ADDR_HOST_WAKE: hostWake_ff <= frameData;
            ADDR_SETTLE_HI: settleHi_ff <= frameData;
            ADDR_SETTLE_LO: settleLo_ff <= frameData;
            ADDR_DWELL: dwell_ff <= frameData;
            default: ;
         endcase
      end
   end

   // Control register: a host write of a request wins over completion
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         control_ff <= RST_ZERO;
      else if (masterReset_ff)
         control_ff <= RST_ZERO;
      else if (regWrite && frameAddr == ADDR_CONTROL)
         control_ff <= frameData & CONTROL_MASK;
      else begin
         if (polFinish)
            control_ff[BIT_POL_REQ] <= 1'b0;
         if (fskFinish)
            control_ff[BIT_FSK_REQ] <= 1'b0;
      end
   end

   // Duty-cycle sequencer
   seq_e seq_ff;
   logic autoCal;
   logic [23:0] unitCnt_ff, unitLen;
   logic [15:0] stepCnt_ff;
   logic unitTick;
   logic [1:0] prescale;
   assign prescale = {options_ff.offPrescaleHigh, options_ff.offPrescaleLow};
   always_comb begin
      if (seq_ff == SEQ_OFF) begin
         unique case (prescale)
            2'h0: unitLen = to24(OFF_BASE0_CYCLES);
            2'h1: unitLen = to24(OFF_BASE1_CYCLES);
            2'h2: unitLen = to24(OFF_BASE2_CYCLES);
            2'h3: unitLen = to24(OFF_BASE3_CYCLES);
         endcase
      end else
         unitLen = to24(WAKE_UNIT_CYCLES);
   end
   assign unitTick = unitCnt_ff + 24'h000001 >= unitLen;

   logic drxOn, seqStart;
   assign drxOn = options_ff.dutyCycledReceiveSelect && !masterReset_ff;
   assign seqStart = csHigh && dioHigh;
   logic [15:0] sleepCount, settleCount;
   assign sleepCount = {sleepHi_ff, sleepLo_ff};
   assign settleCount = {settleHi_ff, settleLo_ff};
   logic [1:0] checkCnt_ff;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         seq_ff <= SEQ_IDLE;
         unitCnt_ff <= 24'h000000;
         stepCnt_ff <= 16'h0000;
         checkCnt_ff <= 2'h0;
      end else if (!drxOn) begin
         seq_ff <= SEQ_IDLE;
         unitCnt_ff <= 24'h000000;
         stepCnt_ff <= 16'h0000;
      end else begin
         unitCnt_ff <= unitTick ? 24'h000000 : unitCnt_ff + 24'h000001;
         if (unitTick)
            stepCnt_ff <= stepCnt_ff + 16'h0001;
         unique case (seq_ff)
            SEQ_IDLE: begin
               unitCnt_ff <= 24'h000000;
               stepCnt_ff <= 16'h0000;
               if (seqStart)
                  seq_ff <= SEQ_OFF;
            end
            SEQ_OFF: begin
               if (stepCnt_ff >= sleepCount) begin
                  seq_ff <= SEQ_HOST_WAKE;
                  unitCnt_ff <= 24'h000000;
                  stepCnt_ff <= 16'h0000;
               end
            end
            SEQ_HOST_WAKE: begin
               if (stepCnt_ff >= {8'h00, hostWake_ff}) begin
                  seq_ff <= SEQ_SETTLE;
                  unitCnt_ff <= 24'h000000;
                  stepCnt_ff <= 16'h0000;
               end
            end
            SEQ_SETTLE: begin
               if (stepCnt_ff >= settleCount) begin
                  seq_ff <= SEQ_CHECK;
                  checkCnt_ff <= 2'h0;
               end
            end
            SEQ_CHECK: begin
               // Let the released line settle through the synchroniser
               checkCnt_ff <= checkCnt_ff + 2'h1;
               if (checkCnt_ff == 2'h3) begin
                  unitCnt_ff <= 24'h000000;
                  stepCnt_ff <= 16'h0000;
                  seq_ff <= dioHigh ? SEQ_OFF : SEQ_ACTIVE;
               end
            end
            SEQ_ACTIVE: begin
               if (seqStart) begin
                  seq_ff <= SEQ_OFF;
                  unitCnt_ff <= 24'h000000;
                  stepCnt_ff <= 16'h0000;
               end
            end
            default: seq_ff <= SEQ_IDLE;
         endcase
      end
   end
   assign autoCal = seq_ff == SEQ_HOST_WAKE &&
      stepCnt_ff >= {8'h00, hostWake_ff} && drxOn;

   // Calibration engines
   logic polPend_ff, fskPend_ff;
   logic [23:0] polCnt_ff, fskCnt_ff, fskLen;
   logic polRun, fskRun;
   assign fskLen = options_ff.longCalibrationSelect ?
      to24(FSK_CAL_LONG_CYCLES) : to24(FSK_CAL_SHORT_CYCLES);
   assign polRun = control_ff[BIT_POL_REQ] || polPend_ff;
   assign fskRun = control_ff[BIT_FSK_REQ] || fskPend_ff;
   assign polFinish = polRun && polCnt_ff + 24'h000001 >=
      to24(POL_CAL_CYCLES);
   assign fskFinish = fskRun && fskCnt_ff + 24'h000001 >= fskLen;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         polPend_ff <= 1'b0;
         fskPend_ff <= 1'b0;
         polCnt_ff <= 24'h000000;
         fskCnt_ff <= 24'h000000;
      end else if (masterReset_ff) begin
         polPend_ff <= 1'b0;
         fskPend_ff <= 1'b0;
         polCnt_ff <= 24'h000000;
         fskCnt_ff <= 24'h000000;
      end else begin
         if (autoCal)
            polPend_ff <= 1'b1;
         else if (polFinish)
            polPend_ff <= 1'b0;
         if (autoCal && power_ff.freqShiftBasebandEnable)
            fskPend_ff <= 1'b1;
         else if (fskFinish)
            fskPend_ff <= 1'b0;
         polCnt_ff <= (polRun && !polFinish) ? polCnt_ff + 24'h000001 :
            24'h000000;
         fskCnt_ff <= (fskRun && !fskFinish) ? fskCnt_ff + 24'h000001 :
            24'h000000;
      end
   end

   // Done flags: completion wins over the clear by a new request
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         polDone_ff <= 1'b0;
         fskDone_ff <= 1'b0;
      end else begin
         if (polFinish)
            polDone_ff <= 1'b1;
         else if (masterReset_ff || (polRun && polCnt_ff == 24'h000000))
            polDone_ff <= 1'b0;
         if (fskFinish)
            fskDone_ff <= 1'b1;
         else if (masterReset_ff || (fskRun && fskCnt_ff == 24'h000000))
            fskDone_ff <= 1'b0;
      end
   end

   // Read path
   logic [7:0] readValue;
   always_comb begin
      unique case (frameAddr)
         ADDR_POWER: readValue = power_ff;
         ADDR_OPTIONS: readValue = options_ff;
         ADDR_CONTROL: readValue = control_ff;
         ADDR_DIVISOR: readValue = divisor_ff;
         ADDR_SLEEP_HI: readValue = sleepHi_ff;
         ADDR_SLEEP_LO: readValue = sleepLo_ff;
         ADDR_HOST_WAKE: readValue = hostWake_ff;
         ADDR_SETTLE_HI: readValue = settleHi_ff;
         ADDR_SETTLE_LO: readValue = settleLo_ff;
         ADDR_STATUS: readValue = {anaSync_ff, 3'h0, polDone_ff,
            fskDone_ff};
         ADDR_DWELL: readValue = dwell_ff;
         default: readValue = 8'h00;
      endcase
   end
   logic readArmed_ff;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         readArmed_ff <= 1'b0;
         readFrame_ff <= 1'b0;
         readShift_ff <= 8'h00;
      end else begin
         if (frameDone && frameCmd == CMD_READ) begin
            readArmed_ff <= 1'b1;
            readShift_ff <= readValue;
         end else if (frameStart && readArmed_ff) begin
            readArmed_ff <= 1'b0;
            readFrame_ff <= 1'b1;
         end else if (frameEnd)
            readFrame_ff <= 1'b0;
         else if (readFrame_ff && sclkFall)
            readShift_ff <= {readShift_ff[6:0], 1'b0};
      end
   end

   // Pin drivers
   logic fourWire;
   assign fourWire = options_ff.freqPinSerialOutEnable ||
      options_ff.ampPinSerialOutEnable;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dioOut <= 1'b1;
         dioOe_n <= 1'b1;
         freqSerialOut <= 1'b0;
         ampSerialOut <= 1'b0;
      end else begin
         freqSerialOut <= readFrame_ff &&
            options_ff.freqPinSerialOutEnable && readShift_ff[7];
         ampSerialOut <= readFrame_ff &&
            options_ff.ampPinSerialOutEnable && readShift_ff[7];
         if (readFrame_ff && !fourWire && !csHigh) begin
            dioOut <= readShift_ff[7];
            dioOe_n <= 1'b0;
         end else if (seq_ff == SEQ_HOST_WAKE || seq_ff == SEQ_SETTLE) begin
            dioOut <= 1'b0;
            dioOe_n <= 1'b0;
         end else begin
            dioOut <= 1'b1;
            dioOe_n <= 1'b1;
         end
      end
   end

   // Module power as seen by the analog sections
   logic awake, settled;
   assign awake = !drxOn || seq_ff == SEQ_SETTLE || seq_ff == SEQ_CHECK ||
      seq_ff == SEQ_ACTIVE;
   assign settled = !drxOn || seq_ff == SEQ_ACTIVE;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         modulePower <= RST_ZERO;
         peakDetectorsEnable <= 1'b0;
         dataOutputsEnable <= 1'b0;
      end else begin
         modulePower <= awake ? power_ff : RST_ZERO;
         if (drxOn && !awake)
            modulePower.deepSleep <= 1'b1;
         if (awake && !settled) begin
            modulePower.freqShiftPeakEnable <= 1'b0;
            modulePower.ampShiftPeakEnable <= 1'b0;
         end
         peakDetectorsEnable <= settled && !power_ff.deepSleep;
         dataOutputsEnable <= settled && !power_ff.deepSleep;
      end
   end

   assign deviceOptions = options_ff;
   assign gainLock = control_ff[6];
   assign freqPeakTrackingEnable = control_ff[3];
   assign ampPeakTrackingEnable = control_ff[2];
   assign crystalDivisor = divisor_ff;
   assign gainReleaseDwell = dwell_ff[4:0] & DWELL_MASK[4:0];
   assign pollingCalibrationBusy = polRun;
   assign freqShiftCalibrationBusy = fskRun;
endmodule

// File: logic/rx_ctrl_pkg.sv
// Constants, field layout and carrier types of the receiver register bank.
// Assumes a 125 MHz system clock sampling a slow serial control port.
package rx_ctrl_pkg;
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned WAKE_UNIT_US = 120;
   localparam int unsigned WAKE_UNIT_CYC = WAKE_UNIT_US * 1000000 /
      CLK_PERIOD_PS;
   localparam int unsigned FRAME_BITS = 16;
   localparam logic [3:0] ADDR_POWER = 4'h0;
   localparam logic [3:0] ADDR_OPTIONS = 4'h1;
   localparam logic [3:0] ADDR_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_DIVISOR = 4'h3;
   localparam logic [3:0] ADDR_SLEEP_HI = 4'h4;
   localparam logic [3:0] ADDR_SLEEP_LO = 4'h5;
   localparam logic [3:0] ADDR_HOST_WAKE = 4'h6;
   localparam logic [3:0] ADDR_SETTLE_HI = 4'h7;
   localparam logic [3:0] ADDR_SETTLE_LO = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'h9;
   localparam logic [3:0] ADDR_DWELL = 4'ha;
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WRITE = 4'h1;
   localparam logic [3:0] CMD_READ = 4'h2;
   localparam logic [3:0] CMD_MASTER_RESET = 4'h3;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_OPTIONS = 8'h40;
   localparam logic [7:0] RST_DWELL = 8'h0d;
   localparam logic [7:0] OPTIONS_MASK = 8'h7f;
   localparam logic [7:0] CONTROL_MASK = 8'h4f;
   localparam logic [7:0] DWELL_MASK = 8'h1f;
   localparam int unsigned BIT_POL_REQ = 1;
   localparam int unsigned BIT_FSK_REQ = 0;

   typedef struct packed {
      logic lowNoiseAmpEnable;
      logic gainControlEnable;
      logic mixerEnable;
      logic freqShiftBasebandEnable;
      logic freqShiftPeakEnable;
      logic ampShiftBasebandEnable;
      logic ampShiftPeakEnable;
      logic deepSleep;
   } power_s;

   typedef struct packed {
      logic unused7;
      logic highGainSelect;
      logic longCalibrationSelect;
      logic freqPinSerialOutEnable;
      logic ampPinSerialOutEnable;
      logic offPrescaleHigh;
      logic offPrescaleLow;
      logic dutyCycledReceiveSelect;
   } options_s;

   typedef struct packed {
      logic synthLocked;
      logic gainState;
      logic crystalRunning;
   } analog_status_s;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h0,
      SEQ_OFF = 3'h1,
      SEQ_HOST_WAKE = 3'h3,
      SEQ_SETTLE = 3'h2,
      SEQ_CHECK = 3'h6,
      SEQ_ACTIVE = 3'h7
   } seq_e;
endpackage
